/* rtl/timer_unit.v */
// Three timer/counters (two four-mode timers and one capture/reload timer).
// Assumes aclk is the oscillator; count, gate and trigger pins are asynchronous.
//
// Operation
// R1 - Timers count once per twelve-clock machine cycle
// R2 - Count pin sampled once per cycle, falling counts
// R3 - Counted value appears at next cycle's update phase
// R4 - Count source at most one twenty-fourth oscillator
// R5 - Mode 0 is 13 bits, low five
// R6 - Rollover to zero sets overflow flag
// R7 - Count enabled by run and gate/pin
// R8 - Setting run keeps count registers intact
// R9 - Gate bits are mode bits 7 and 3
// R10 - Mode 1 counts 16 bits, flags, continues
// R11 - Mode 2 low byte reloads from high byte
// R12 - Timer 1 mode 3 holds count
// R13 - Timer 0 mode 3 splits into two bytes
// R14 - Timer 1 runs by leaving mode 3
// R15 - Timer 2 mode from run, clocks, select
// R16 - Capture mode trigger edge copies count
// R17 - Capture mode overflow sets overflow flag
// R18 - Reload mode reloads on overflow or trigger
// R19 - Serial clock select forces auto-reload
// R20 - Trigger edge sets external flag; in baud mode the code ignores the trigger edge
// R21 - Timer 2 counter select picks source
// R22 - Mode encodings 13, 16, 8-reload, split
// R23 - Timer 2 or 1 overflow drives serial clocks
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_regs.vh"
module timer_unit (
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire count_pin0,
   input wire count_pin1,
   input wire count_pin2,
   input wire ext_irq0_pin,
   input wire ext_irq1_pin,
   input wire t2_trigger_pin,
   output reg serial_rx_clock,
   output reg serial_tx_clock
);

   // Registers
   reg [7:0] timer_run_flag_reg;
   reg [7:0] timer_mode_reg;
   reg [7:0] timer2_control;
   reg [7:0] t0_low_byte, t0_high_byte, t1_low_byte, t1_high_byte;
   reg [7:0] t2_low_byte, t2_high_byte, t2_capture_low, t2_capture_high;
   reg [`PHASE_W-1:0] phase_reg;
   // Pin synchronisers, then per-cycle samples
   reg [5:0] pin_meta_reg, pin_sync_reg, pin_sample_reg, pin_prev_reg, pin_fall_reg;
   // AXI holding state
   reg [4:0] aw_addr_reg;
   reg aw_have_reg, w_have_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // Mode field decode, used for both timers
   function [1:0] mode_of;
      input [3:0] nib;
      begin
         mode_of = nib[1:0];
      end
   endfunction

   // Edge-count select: counter pin falling edge or machine cycle tick
   function tick_of;
      input ct;
      input fall;
      input cyc;
      begin
         tick_of = ct ? fall : cyc;
      end
   endfunction

   wire [1:0] t0_mode = mode_of(timer_mode_reg[3:0]); // R22
   wire [1:0] t1_mode = mode_of(timer_mode_reg[7:4]); // R22
   // Counting is applied once per machine cycle, at the update phase
   wire cycle_tick = clk_en && (phase_reg == `PHASE_UPDATE); // R1 R3
   // Gating: run and (gate off or pin high), gates at bits 3 and 7
   wire t0_enable = timer_run_flag_reg[`RF_T0_RUN] &&
      (!timer_mode_reg[`MD_GATE] || pin_sync_reg[3]); // R7 R9
   wire t1_enable = timer_run_flag_reg[`RF_T1_RUN] &&
      (!timer_mode_reg[4+`MD_GATE] || pin_sync_reg[4]) && (t1_mode != 2'b11); // R7 R9 R12 R14
   wire t0_tick = cycle_tick && t0_enable &&
      tick_of(timer_mode_reg[`MD_CT], pin_fall_reg[0], 1'b1); // R2
   wire t1_tick = cycle_tick && t1_enable &&
      tick_of(timer_mode_reg[4+`MD_CT], pin_fall_reg[1], 1'b1); // R2
   // Split mode: high byte of timer 0 counts cycles under timer 1 run bit
   wire t0h_tick = cycle_tick && (t0_mode == 2'b11) && timer_run_flag_reg[`RF_T1_RUN]; // R13
   wire t2_baud = timer2_control[`T2_RXSEL] || timer2_control[`T2_TXSEL]; // R15
   wire t2_tick = cycle_tick && timer2_control[`T2_RUN] &&
      tick_of(timer2_control[`T2_CT], pin_fall_reg[2], 1'b1); // R21 R15
   wire t2_trig = cycle_tick && timer2_control[`T2_EXEN] && pin_fall_reg[5] && !t2_baud;

   // Next counts for timers 0 and 1 with overflow
   reg [7:0] t0l_n, t0h_n, t1l_n, t1h_n;
   reg t0_ovf, t1_ovf, t0h_ovf;
   always @* begin
      t0l_n = t0_low_byte;
      t0h_n = t0_high_byte;
      t0_ovf = 1'b0;
      t0h_ovf = 1'b0;
      if (t0_tick) begin
         case (t0_mode)
            2'b00: begin // R5
               t0l_n = {t0_low_byte[7:5], t0_low_byte[4:0] + 5'h01};
               if (t0_low_byte[4:0] == 5'h1f) begin
                  t0h_n = t0_high_byte + 8'h01;
                  t0_ovf = (t0_high_byte == 8'hff); // R6
               end
            end
            2'b01: begin // R10
               {t0h_n, t0l_n} = {t0_high_byte, t0_low_byte} + 16'h0001;
               t0_ovf = ({t0_high_byte, t0_low_byte} == 16'hffff);
            end
            2'b10: begin // R11
               t0l_n = (t0_low_byte == 8'hff) ? t0_high_byte : t0_low_byte + 8'h01;
               t0_ovf = (t0_low_byte == 8'hff);
            end
            default: begin // R13
               t0l_n = t0_low_byte + 8'h01;
               t0_ovf = (t0_low_byte == 8'hff);
            end
         endcase
      end
      if (t0h_tick) begin
         t0h_n = t0_high_byte + 8'h01;
         t0h_ovf = (t0_high_byte == 8'hff);
      end
   end

   always @* begin
      t1l_n = t1_low_byte;
      t1h_n = t1_high_byte;
      t1_ovf = 1'b0;
      if (t1_tick) begin
         case (t1_mode)
            2'b00: begin // R5
               t1l_n = {t1_low_byte[7:5], t1_low_byte[4:0] + 5'h01};
               if (t1_low_byte[4:0] == 5'h1f) begin
                  t1h_n = t1_high_byte + 8'h01;
                  t1_ovf = (t1_high_byte == 8'hff); // R6
               end
            end
            2'b01: begin // R10
               {t1h_n, t1l_n} = {t1_high_byte, t1_low_byte} + 16'h0001;
               t1_ovf = ({t1_high_byte, t1_low_byte} == 16'hffff);
            end
            2'b10: begin // R11
               t1l_n = (t1_low_byte == 8'hff) ? t1_high_byte : t1_low_byte + 8'h01;
               t1_ovf = (t1_low_byte == 8'hff);
            end
            default: begin // R12
               t1l_n = t1_low_byte;
            end
         endcase
      end
   end

   // Timer 2: count, overflow, capture or reload
   reg [15:0] t2_n, cap_n;
   reg t2_ovf;
   always @* begin
      t2_n = {t2_high_byte, t2_low_byte};
      cap_n = {t2_capture_high, t2_capture_low};
      t2_ovf = 1'b0;
      if (t2_tick) begin
         t2_ovf = (t2_n == 16'hffff);
         // Baud mode always reloads regardless of capture select
         if (t2_ovf && (t2_baud || !timer2_control[`T2_CPRL])) // R18 R19
            t2_n = cap_n;
         else
            t2_n = t2_n + 16'h0001; // R17
      end
      if (t2_trig) begin
         if (timer2_control[`T2_CPRL])
            cap_n = t2_n; // R16
         else
            t2_n = {t2_capture_high, t2_capture_low}; // R18
      end
   end

   // AXI write acceptance: address and data in either order
   wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire [7:0] wbyte = w_data_reg[7:0];
   wire wlane = w_strb_reg[0];
   wire wr_ok = (aw_addr_reg <= `OFS_T2_CONTROL) && (aw_addr_reg[1:0] == 2'b00);
   wire wr_run = do_write && wlane && (aw_addr_reg == `OFS_RUN_FLAG);
   wire wr_mode = do_write && wlane && (aw_addr_reg == `OFS_MODE);
   wire wr_t0 = do_write && (aw_addr_reg == `OFS_T0);
   wire wr_t1 = do_write && (aw_addr_reg == `OFS_T1);
   wire wr_t2 = do_write && (aw_addr_reg == `OFS_T2);
   wire wr_cap = do_write && (aw_addr_reg == `OFS_T2_CAPTURE);
   wire wr_t2c = do_write && wlane && (aw_addr_reg == `OFS_T2_CONTROL);

   // Pin sampling: two flops, then one sample per machine cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_reg <= 6'h00;
         pin_sync_reg <= 6'h00;
         pin_sample_reg <= 6'h00;
         pin_prev_reg <= 6'h00;
         pin_fall_reg <= 6'h00;
         phase_reg <= {`PHASE_W{1'b0}};
      end else if (clk_en) begin
         pin_meta_reg <= {t2_trigger_pin, ext_irq1_pin, ext_irq0_pin, count_pin2, count_pin1, count_pin0};
         pin_sync_reg <= pin_meta_reg;
         phase_reg <= (phase_reg == `PHASE_LAST) ? {`PHASE_W{1'b0}} : phase_reg + 4'h1; // R1
         if (phase_reg == `PHASE_SAMPLE) begin
            // High in one sample, low in the next counts; limits rate to 1/24
            pin_prev_reg <= pin_sample_reg; // R4
            pin_sample_reg <= pin_sync_reg; // R2
            pin_fall_reg <= pin_sample_reg & ~pin_sync_reg; // R2
         end
      end
   end

   // Timer state; hardware set wins over a software write in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_run_flag_reg <= `RESET_BYTE;
         timer_mode_reg <= `RESET_BYTE;
         timer2_control <= `RESET_BYTE;
         t0_low_byte <= `RESET_BYTE;
         t0_high_byte <= `RESET_BYTE;
         t1_low_byte <= `RESET_BYTE;
         t1_high_byte <= `RESET_BYTE;
         t2_low_byte <= `RESET_BYTE;
         t2_high_byte <= `RESET_BYTE;
         t2_capture_low <= `RESET_BYTE;
         t2_capture_high <= `RESET_BYTE;
         serial_rx_clock <= 1'b0;
         serial_tx_clock <= 1'b0;
      end else if (clk_en) begin
         // Run bits only touch control, never the counts
         if (wr_run)
            timer_run_flag_reg <= wbyte; // R8
         if (t0_ovf)
            timer_run_flag_reg[`RF_T0_OVF] <= 1'b1; // R6
         if (t1_ovf || t0h_ovf)
            timer_run_flag_reg[`RF_T1_OVF] <= 1'b1; // R13
         if (wr_mode)
            timer_mode_reg <= wbyte;
         if (wr_t2c)
            timer2_control <= wbyte;
         if (t2_ovf && !t2_baud)
            timer2_control[`T2_OVF] <= 1'b1; // R17
         if (t2_trig)
            timer2_control[`T2_EXT] <= 1'b1; // R20
         t0_low_byte <= (wr_t0 && w_strb_reg[0]) ? w_data_reg[7:0] : t0l_n;
         t0_high_byte <= (wr_t0 && w_strb_reg[1]) ? w_data_reg[15:8] : t0h_n;
         t1_low_byte <= (wr_t1 && w_strb_reg[0]) ? w_data_reg[7:0] : t1l_n;
         t1_high_byte <= (wr_t1 && w_strb_reg[1]) ? w_data_reg[15:8] : t1h_n;
         t2_low_byte <= (wr_t2 && w_strb_reg[0]) ? w_data_reg[7:0] : t2_n[7:0];
         t2_high_byte <= (wr_t2 && w_strb_reg[1]) ? w_data_reg[15:8] : t2_n[15:8];
         t2_capture_low <= (wr_cap && w_strb_reg[0]) ? w_data_reg[7:0] : cap_n[7:0];
         t2_capture_high <= (wr_cap && w_strb_reg[1]) ? w_data_reg[15:8] : cap_n[15:8];
         // One-cycle baud pulses from the selected overflow source
         serial_rx_clock <= timer2_control[`T2_RXSEL] ? t2_ovf : t1_ovf; // R23
         serial_tx_clock <= timer2_control[`T2_TXSEL] ? t2_ovf : t1_ovf; // R23
      end
   end

   // AXI write channels
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI read channel, one outstanding read
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
               `OFS_RUN_FLAG: s_axi_rdata <= {24'h000000, timer_run_flag_reg};
               `OFS_MODE: s_axi_rdata <= {24'h000000, timer_mode_reg};
               `OFS_T0: s_axi_rdata <= {16'h0000, t0_high_byte, t0_low_byte};
               `OFS_T1: s_axi_rdata <= {16'h0000, t1_high_byte, t1_low_byte};
               `OFS_T2: s_axi_rdata <= {16'h0000, t2_high_byte, t2_low_byte};
               `OFS_T2_CAPTURE: s_axi_rdata <= {16'h0000, t2_capture_high, t2_capture_low};
               `OFS_T2_CONTROL: s_axi_rdata <= {24'h000000, timer2_control};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* rtl/timer_unit_regs.vh */
// Register offsets, field positions, reset values and timing for the timer unit.
// Assumes inclusion by the timer unit design file only.
`ifndef TIMER_UNIT_REGS_VH
`define TIMER_UNIT_REGS_VH
// Byte offsets on the register bus
`define OFS_RUN_FLAG 5'h00
`define OFS_MODE 5'h04
`define OFS_T0 5'h08
`define OFS_T1 5'h0c
`define OFS_T2 5'h10
`define OFS_T2_CAPTURE 5'h14
`define OFS_T2_CONTROL 5'h18
// Run/flag register fields
`define RF_T0_RUN 4
`define RF_T0_OVF 5
`define RF_T1_RUN 6
`define RF_T1_OVF 7
// Mode register fields, per timer nibble
`define MD_GATE 3
`define MD_CT 2
// Timer 2 control fields
`define T2_OVF 7
`define T2_EXT 6
`define T2_RXSEL 5
`define T2_TXSEL 4
`define T2_EXEN 3
`define T2_RUN 2
`define T2_CT 1
`define T2_CPRL 0
// Reset values
`define RESET_BYTE 8'h00
// Timing: oscillator periods per machine cycle, oscillator = aclk
`define OSC_PER_MACHINE 12
`define PHASE_W 4
`define PHASE_LAST 4'hb
`define PHASE_SAMPLE 4'h9
`define PHASE_UPDATE 4'h4
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* testbench/timer_unit_assertions.sv */
// Port-level checker for the timer unit: bus handshakes and serial clock pulses.
// Assumes binding to timer_unit, one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_rx_clock,
   input wire logic serial_tx_clock
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Answers stand until taken, and read data with them
   property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
   property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped or changed");
   // Answer latency as handed over
   property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
   property p_write_answer; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
   a_write_answer: assert property (p_write_answer) else $error("write response late");
   property p_aw_cause; $rose(s_axi_awready) |-> $past(s_axi_awvalid); endproperty
   a_aw_cause: assert property (p_aw_cause) else $error("write address ready without request");
   property p_err_zero; s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
   // Overflow pulses last one clock and are followed by at least eight low clocks
   property p_rx_pulse; serial_rx_clock |=> !serial_rx_clock [*8]; endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("receive clock pulse malformed");
   property p_tx_pulse; serial_tx_clock |=> !serial_tx_clock [*8]; endproperty
   a_tx_pulse: assert property (p_tx_pulse) else $error("transmit clock pulse malformed");
endmodule
bind timer_unit timer_unit_assertions timer_unit_assertions_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .serial_rx_clock, .serial_tx_clock);
`default_nettype wire

/* testbench/timer_pins_model.sv */
// Far-side model of the count and trigger pins, making one falling edge per request.
// Assumes one-clock requests from the bench; pins idle high as with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module timer_pins_model (
   input wire logic aclk,
   input wire logic [3:0] fall_req,
   output logic [3:0] pins,
   output logic [3:0] busy
);
   int cnt [4];
   initial pins = 4'hf;
   // Low 14 clocks then high 14: both levels outlast a machine cycle
   always @(posedge aclk) begin
      for (int i = 0; i < 4; i++) begin
         if (cnt[i] != 0) begin
            cnt[i] <= cnt[i] - 1;
            if (cnt[i] == 15) pins[i] <= 1'h1;
         end else if (fall_req[i]) begin
            cnt[i] <= 28;
            pins[i] <= 1'h0;
         end
      end
   end
   always_comb for (int i = 0; i < 4; i++) busy[i] = (cnt[i] != 0);
endmodule
`default_nettype wire

/* testbench/timer_unit_tb.sv */
// Self-checking bench for the timer unit through its register bus and pins.
// Assumes timer_pins_model drives edge pins; gate 0 pin is driven here.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_tb;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, irq0 = 0;
   logic [4:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0] fall_req = 0;
   logic [15:0] pre;
   wire [3:0] pins, busy;
   wire awready, wready, bvalid, arready, rvalid, rx, tx;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   exp_t rq[$];
   logic [1:0] wq[$];
   int fails = 0, checks = 0, seed = 8693, rxn = 0, txn = 0;
   timer_unit timer_unit_i (.aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_pin0(pins[0]),
      .count_pin1(pins[1]), .count_pin2(pins[2]), .ext_irq0_pin(irq0), .ext_irq1_pin(1'h0),
      .t2_trigger_pin(pins[3]), .serial_rx_clock(rx), .serial_tx_clock(tx));
   timer_pins_model timer_pins_model_i (.aclk, .fall_req, .pins, .busy);
   always #5 aclk = ~aclk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Monitor: oldest note against each answer; counts serial pulses
   always @(posedge aclk) begin
      exp_t e;
      if (rvalid && rready) begin
         e = rq.pop_front();
         check(rdata & e.m, e.d);
         check({30'h0, rresp}, {30'h0, e.r});
      end
      if (bvalid && bready) check({30'h0, bresp}, {30'h0, wq.pop_front()});
      if (rx === 1'h1) rxn <= rxn + 1;
      if (tx === 1'h1) txn <= txn + 1;
   end
   // Response ready raised late on purpose, so answers must stand
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      int n = 0;
      wq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (++n > 100) begin fails++; finish_test(); end
      end while (!bvalid);
      bready <= 1'h1;
      @(posedge aclk);
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m = '1,
                     input logic [1:0] r = 2'h0);
      int n = 0;
      rq.push_back('{d, m, r});
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (++n > 100) begin fails++; finish_test(); end
      end while (!rvalid);
      rready <= 1'h1;
      @(posedge aclk);
      rready <= 1'h0;
   endtask
   task automatic falls(input int i, input int k);
      repeat (k) begin
         fall_req[i] <= 1'h1;
         @(posedge aclk);
         fall_req[i] <= 1'h0;
         for (int n = 0; n < 40 && (n == 0 || busy[i]); n++) @(posedge aclk);
         if (busy[i]) begin fails++; finish_test(); end
      end
      repeat (30) @(posedge aclk);
   endtask
   // Gate window of exactly k machine cycles on timer 0
   task automatic t0_case(input logic [7:0] md, input logic [15:0] v, input int k, input logic [31:0] m,
                          input logic [15:0] e);
      wr(5'h04, {24'h0, md});
      wr(5'h08, {16'h0, v});
      wr(5'h00, 32'h10);
      rd(5'h08, {16'h0, v});
      irq0 <= 1'h1;
      repeat (12 * k) @(posedge aclk);
      irq0 <= 1'h0;
      repeat (40) @(posedge aclk);
      rd(5'h08, {16'h0, e}, m);
      rd(5'h00, 32'h30);
      wr(5'h00, 32'h0);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      // Reset values, then an unmapped place
      for (int a = 0; a < 28; a += 4) rd(a[4:0], 32'h0);
      rd(5'h1c, 32'h0, '1, 2'h2);
      wr(5'h1c, 32'hff, 2'h2);
      t0_case(8'h08, 16'hff1e, 2, 32'hff1f, 16'h0000);
      t0_case(8'h09, 16'hfffe, 3, 32'hffff, 16'h0001);
      t0_case(8'h0a, 16'h80fe, 3, 32'hffff, 16'h8081);
      // Timer 1 counts pin edges from a random start; mode 3 freezes it
      pre = $random(seed);
      wr(5'h04, 32'h5b);
      wr(5'h0c, {16'h0, pre});
      wr(5'h00, 32'h40);
      falls(1, 3);
      rd(5'h0c, {16'h0, pre + 16'h3});
      rd(5'h00, {24'h0, (pre > 16'hfffc) ? 8'hc0 : 8'h40}, 32'hff);
      wr(5'h04, 32'h7b);
      falls(1, 2);
      rd(5'h0c, {16'h0, pre + 16'h3});
      wr(5'h04, 32'h5b);
      falls(1, 1);
      rd(5'h0c, {16'h0, pre + 16'h4});
      // Timer 2 capture: overflow, then a trigger edge copies the count
      wr(5'h10, 32'hfffe);
      wr(5'h18, 32'h0f);
      falls(2, 3);
      falls(3, 1);
      rd(5'h14, 32'h0001);
      rd(5'h18, 32'hcf);
      wr(5'h18, 32'h0b);
      falls(2, 1);
      rd(5'h10, 32'h0001);
      // Auto-reload on overflow and on a trigger edge
      wr(5'h14, 32'h1234);
      wr(5'h10, 32'hffff);
      wr(5'h18, 32'h0e);
      falls(2, 1);
      rd(5'h10, 32'h1234);
      wr(5'h10, 32'h0);
      falls(3, 1);
      rd(5'h10, 32'h1234);
      rd(5'h18, 32'hce);
      // Baud mode ignores the capture select; each serial clock pulses once
      wr(5'h14, 32'habcd);
      wr(5'h10, 32'hfffe);
      rxn = 0;
      txn = 0;
      wr(5'h18, 32'h37);
      falls(2, 2);
      rd(5'h10, 32'habcd);
      check(rxn, 32'h1);
      check(txn, 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
